// ### hdl/sbd_access_seq.sv
// Splits one CPU access into device-width bus beats with wait cycles
`timescale 1ns/1ns
`include "sbd_cfg.svh"
module sbd_access_seq (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic req_valid_in,
	input wire sbd_pkg::sbd_cpu_req_t req_in,
	input wire sbd_pkg::sbd_decode_t dec_in,
	input wire logic hold_in,
	input wire logic [31:0] local_rdata_in,
	input wire logic [7:0] status_in,
	input wire logic [31:0] bus_rdata_in,
	output logic req_ready_out,
	output logic resp_valid_out,
	output logic [31:0] resp_rdata_out,
	output logic busy_out,
	output sbd_pkg::sbd_area_t area_out,
	output sbd_pkg::sbd_bus_req_t bus_out
);
	typedef enum logic {SBD_ST_IDLE, SBD_ST_BEAT} sbd_state_t;
	sbd_state_t state;
	logic [1:0] size;
	logic [1:0] width;
	logic we;
	logic stack;
	logic [23:0] addr;
	logic [31:0] wdata;
	logic [31:0] acc;
	logic [31:0] lane;
	logic [31:0] next_acc;
	logic [31:0] final_data;
	logic [2:0] cycles;
	logic [2:0] wait_cnt;
	logic [2:0] beats;
	logic [4:0] pos;
	logic accept;
	logic beat_end;
	logic last;

	function automatic logic [2:0] beat_count(input logic [1:0] sz,
		input logic [1:0] wd);
		beat_count = `SBD_ONE_BEAT;
		if (sz > wd)
			beat_count = `SBD_ONE_BEAT << (sz - wd);
	endfunction

	function automatic logic [31:0] mask_of(input logic [1:0] w);
		case (w)
			`SBD_W8: mask_of = `SBD_MASK8;
			`SBD_W16: mask_of = `SBD_MASK16;
			default: mask_of = `SBD_MASK32;
		endcase
	endfunction

	assign req_ready_out = state == SBD_ST_IDLE && !hold_in;
	assign accept = ce_in && req_valid_in && req_ready_out;
	assign busy_out = state != SBD_ST_IDLE;
	assign beat_end = busy_out && wait_cnt == `SBD_CYC_ONE;
	assign last = beat_end && beats == `SBD_ONE_BEAT;
	assign bus_out = {busy_out, we, width, addr, wdata};

	always_comb begin
		lane = bus_rdata_in & mask_of(width);
		next_acc = acc | (lane << pos);
		final_data = next_acc & mask_of(size);
		// top byte dropped on plain 32-bit reads
		if (size == `SBD_SZ_WORD && !stack)
			final_data = final_data & `SBD_LOW24;
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			state <= SBD_ST_IDLE;
		else if (ce_in) begin
			if (accept && !dec_in.local_only)
				state <= SBD_ST_BEAT;
			else if (last)
				state <= SBD_ST_IDLE;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			addr <= '0;
			wdata <= '0;
			size <= '0;
			width <= '0;
			we <= 1'b0;
			stack <= 1'b0;
			cycles <= `SBD_CYC_ONE;
			wait_cnt <= `SBD_CYC_ONE;
			beats <= `SBD_ONE_BEAT;
			area_out <= sbd_pkg::SBD_AREA_NONE;
			pos <= '0;
			acc <= '0;
		end else if (ce_in) begin
			if (accept) begin
				addr <= req_in.addr;
				size <= req_in.size;
				we <= req_in.we;
				stack <= req_in.stack;
				width <= dec_in.width;
				cycles <= dec_in.cycles;
				wait_cnt <= dec_in.cycles;
				area_out <= dec_in.area;
				pos <= '0;
				acc <= '0;
				// beats from access size and device width
				beats <= beat_count(req_in.size, dec_in.width);
				wdata <= req_in.wdata;
				// top byte zero, or status when stacking
				if (req_in.size == `SBD_SZ_WORD)
					wdata <= {req_in.stack ? status_in : `SBD_ZERO_BYTE,
						req_in.wdata[23:0]};
			end else if (beat_end) begin
				acc <= next_acc;
				wait_cnt <= cycles;
				beats <= beats - `SBD_ONE_BEAT;
				// next higher address, next higher lane
				addr <= addr + (`SBD_ONE_ADDR << width);
				wdata <= wdata >> (`SBD_BYTE_BITS << width);
				pos <= pos + (`SBD_BYTE_BITS << width);
			end else if (busy_out)
				wait_cnt <= wait_cnt - `SBD_CYC_ONE;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			resp_valid_out <= 1'b0;
			resp_rdata_out <= '0;
		end else if (ce_in) begin
			resp_valid_out <= 1'b0;
			if (accept && dec_in.local_only) begin
				resp_valid_out <= 1'b1;
				resp_rdata_out <= local_rdata_in & mask_of(req_in.size);
			end else if (last) begin
				resp_valid_out <= 1'b1;
				resp_rdata_out <= final_data;
			end
		end
	end

	property p_beat_count;
		@(posedge mclk_in) disable iff (!resetn_in)
		accept && !dec_in.local_only |=>
			beats == beat_count($past(req_in.size), $past(dec_in.width));
	endproperty
	a_beat_count: assert property (p_beat_count)
		else $error("beat count does not match size and width");

	property p_addr_step;
		@(posedge mclk_in) disable iff (!resetn_in)
		ce_in && beat_end && beats != `SBD_ONE_BEAT |=>
			addr == $past(addr) + (`SBD_ONE_ADDR << $past(width));
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("split access did not step upward");

	property p_top_zero;
		@(posedge mclk_in) disable iff (!resetn_in)
		resp_valid_out && size == `SBD_SZ_WORD && !stack && !we |->
			resp_rdata_out[31:24] == `SBD_ZERO_BYTE;
	endproperty
	a_top_zero: assert property (p_top_zero)
		else $error("top byte of 32-bit read not dropped");

	property p_slow_flash;
		@(posedge mclk_in) disable iff (!resetn_in)
		accept && !dec_in.local_only && dec_in.cycles == `SBD_FL_CYC_MAX
		|=> busy_out [*5];
	endproperty
	a_slow_flash: assert property (p_slow_flash)
		else $error("five-cycle beat ended early");
endmodule

// ### hdl/sbd_area_decode.sv
// Address decoder giving area, device width and cycles per bus access
`timescale 1ns/1ns
`include "sbd_cfg.svh"
module sbd_area_decode (
	input wire logic [23:0] addr_in,
	input wire logic [1:0] size_in,
	input wire logic we_in,
	input wire logic [2:0] flash_cycles_in,
	output sbd_pkg::sbd_decode_t dec_out
);
	logic [2:0] fl_cyc;

	// Out of range settings are clamped rather than trusted
	always_comb begin
		fl_cyc = flash_cycles_in;
		if (flash_cycles_in == `SBD_CYC_NONE)
			fl_cyc = `SBD_CYC_ONE;
		else if (flash_cycles_in > `SBD_FL_CYC_MAX)
			fl_cyc = `SBD_FL_CYC_MAX;
	end

	always_comb begin
		dec_out.area = sbd_pkg::SBD_AREA_NONE;
		dec_out.width = `SBD_W8;
		dec_out.cycles = `SBD_CYC_ONE;
		dec_out.local_only = 1'b0;
		if (addr_in >= `SBD_DBG_BASE && addr_in <= `SBD_RAM_END) begin
			dec_out.area = sbd_pkg::SBD_AREA_DBG;
			dec_out.width = `SBD_W32;
		end else if (addr_in <= `SBD_RAM_END) begin
			dec_out.area = sbd_pkg::SBD_AREA_RAM;
			dec_out.width = `SBD_W32;
		end else if (addr_in >= `SBD_P1_BASE && addr_in <= `SBD_P1_END) begin
			dec_out.area = sbd_pkg::SBD_AREA_P1;
			if (addr_in > `SBD_P1_NARROW_END)
				dec_out.width = `SBD_W16;
		end else if (addr_in >= `SBD_P2_BASE && addr_in <= `SBD_P2_END) begin
			dec_out.area = sbd_pkg::SBD_AREA_P2;
			if (addr_in >= `SBD_DISP_BASE && addr_in <= `SBD_DISP_END)
				dec_out.area = sbd_pkg::SBD_AREA_DISP;
			if (addr_in >= `SBD_P2_WIDE_BASE)
				dec_out.width = `SBD_W16;
			if (addr_in == `SBD_MIRROR_ADDR || addr_in == `SBD_MIRROR_LAST)
				dec_out.local_only = 1'b1;
		// flash, 16-bit, 1 to 5 cycles
		end else if (addr_in >= `SBD_FL_BASE && addr_in <= `SBD_FL_END) begin
			dec_out.area = sbd_pkg::SBD_AREA_FLASH;
			dec_out.width = `SBD_W16;
			dec_out.cycles = fl_cyc;
			if (we_in && size_in != `SBD_SZ_HALF)
				dec_out.local_only = 1'b1;
		end else if (addr_in >= `SBD_CORE_BASE) begin
			dec_out.area = sbd_pkg::SBD_AREA_CORE;
			if (addr_in == `SBD_ID_ADDR)
				dec_out.local_only = 1'b1;
		end else begin
			dec_out.local_only = 1'b1;
		end
	end
endmodule

// ### hdl/sbd_bus_front.sv
// System bus front end: decode, split, serialise, status mirror and ID
`timescale 1ns/1ns
`include "sbd_cfg.svh"
module sbd_bus_front #(
	// Value is arbitrary
	parameter logic [7:0] CORE_ID = `SBD_ID_CODE
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire sbd_pkg::sbd_status_t core_status_word_in,
	input wire logic [2:0] flash_cycles_in,
	input wire logic fetch_valid_in,
	input wire sbd_pkg::sbd_cpu_req_t fetch_req_in,
	output logic fetch_ready_out,
	output logic fetch_resp_valid_out,
	output logic [31:0] fetch_rdata_out,
	input wire logic data_valid_in,
	input wire sbd_pkg::sbd_cpu_req_t data_req_in,
	output logic data_ready_out,
	output logic data_resp_valid_out,
	output logic [31:0] data_rdata_out,
	output sbd_pkg::sbd_bus_req_t fetch_bus_out,
	input wire logic [31:0] fetch_bus_rdata_in,
	output sbd_pkg::sbd_bus_req_t data_bus_out,
	input wire logic [31:0] data_bus_rdata_in
);
	sbd_pkg::sbd_status_t processor_status_mirror;
	sbd_pkg::sbd_cpu_req_t fetch_req;
	sbd_pkg::sbd_decode_t dec_f;
	sbd_pkg::sbd_decode_t dec_d;
	sbd_pkg::sbd_area_t f_area;
	sbd_pkg::sbd_area_t d_area;
	sbd_pkg::sbd_area_t d_cur;
	logic f_busy;
	logic d_busy;
	logic f_hold;
	logic d_hold;
	logic d_acc;
	logic [31:0] f_local;
	logic [31:0] d_local;

	function automatic logic conflict(input sbd_pkg::sbd_area_t fa,
		input sbd_pkg::sbd_area_t da);
		conflict = 1'b0;
		// flash fetch against flash or display data
		if (fa == sbd_pkg::SBD_AREA_FLASH &&
			(da == sbd_pkg::SBD_AREA_FLASH || da == sbd_pkg::SBD_AREA_DISP))
			conflict = 1'b1;
		if ((fa == sbd_pkg::SBD_AREA_RAM || fa == sbd_pkg::SBD_AREA_DBG) &&
			(da == sbd_pkg::SBD_AREA_RAM || da == sbd_pkg::SBD_AREA_DBG))
			conflict = 1'b1;
	endfunction

	function automatic logic [31:0] local_read(input logic [23:0] a,
		input sbd_pkg::sbd_status_t st, input logic [7:0] id);
		local_read = `SBD_ZERO_WORD;
		// status byte in low lane, upper byte zero
		if (a == `SBD_MIRROR_ADDR)
			local_read = {`SBD_ZERO_BYTE, `SBD_ZERO_BYTE,
				`SBD_ZERO_BYTE, st};
		else if (a == `SBD_ID_ADDR)
			local_read = {`SBD_ZERO_BYTE, `SBD_ZERO_BYTE,
				`SBD_ZERO_BYTE, id};
	endfunction

	// mirror tracks the core, zero from reset
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in)
			processor_status_mirror <= `SBD_MIRROR_RST;
		else if (ce_in)
			processor_status_mirror <= core_status_word_in;
	end

	// Fetches never write
	always_comb begin
		fetch_req = fetch_req_in;
		fetch_req.we = 1'b0;
	end

	// writes to the mirror only get the local answer
	assign f_local = local_read(fetch_req.addr, processor_status_mirror,
		CORE_ID);
	assign d_local = data_req_in.we ? `SBD_ZERO_WORD :
		local_read(data_req_in.addr, processor_status_mirror, CORE_ID);

	// Data access wins a same-cycle request; the fetch is stretched by its cycles
	assign d_cur = d_busy ? d_area : dec_d.area;
	// hold the fetch while conflicting data runs
	assign f_hold = conflict(dec_f.area, d_cur) &&
		(d_busy || (data_valid_in && !dec_d.local_only));
	assign d_hold = conflict(f_area, dec_d.area) && f_busy &&
		!dec_d.local_only;
	assign d_acc = ce_in && data_valid_in && data_ready_out;

	sbd_area_decode u_dec_fetch (
		.addr_in(fetch_req.addr),
		.size_in(fetch_req.size),
		.we_in(fetch_req.we),
		.flash_cycles_in(flash_cycles_in),
		.dec_out(dec_f)
	);

	sbd_area_decode u_dec_data (
		.addr_in(data_req_in.addr),
		.size_in(data_req_in.size),
		.we_in(data_req_in.we),
		.flash_cycles_in(flash_cycles_in),
		.dec_out(dec_d)
	);

	sbd_access_seq u_seq_fetch (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.req_valid_in(fetch_valid_in),
		.req_in(fetch_req),
		.dec_in(dec_f),
		.hold_in(f_hold),
		.local_rdata_in(f_local),
		.status_in(processor_status_mirror),
		.bus_rdata_in(fetch_bus_rdata_in),
		.req_ready_out(fetch_ready_out),
		.resp_valid_out(fetch_resp_valid_out),
		.resp_rdata_out(fetch_rdata_out),
		.busy_out(f_busy),
		.area_out(f_area),
		.bus_out(fetch_bus_out)
	);

	sbd_access_seq u_seq_data (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.req_valid_in(data_valid_in),
		.req_in(data_req_in),
		.dec_in(dec_d),
		.hold_in(d_hold),
		.local_rdata_in(d_local),
		.status_in(core_status_word_in),
		.bus_rdata_in(data_bus_rdata_in),
		.req_ready_out(data_ready_out),
		.resp_valid_out(data_resp_valid_out),
		.resp_rdata_out(data_rdata_out),
		.busy_out(d_busy),
		.area_out(d_area),
		.bus_out(data_bus_out)
	);

	property p_mirror_read;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && !data_req_in.we && data_req_in.addr == `SBD_MIRROR_ADDR
		|=> data_resp_valid_out &&
			data_rdata_out[7:0] == $past(processor_status_mirror);
	endproperty
	a_mirror_read: assert property (p_mirror_read)
		else $error("mirror read returned wrong status");

	property p_mirror_ro;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && data_req_in.we && data_req_in.addr == `SBD_MIRROR_ADDR
		|=> data_resp_valid_out && !data_bus_out.req;
	endproperty
	a_mirror_ro: assert property (p_mirror_ro)
		else $error("mirror write reached the bus");

	property p_mirror_high;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && !data_req_in.we && data_req_in.addr == `SBD_MIRROR_ADDR
		&& data_req_in.size == `SBD_SZ_HALF
		|=> data_rdata_out[15:8] == `SBD_ZERO_BYTE;
	endproperty
	a_mirror_high: assert property (p_mirror_high)
		else $error("mirror upper byte not zero");

	property p_mirror_reset;
		@(posedge mclk_in) disable iff (!resetn_in)
		$rose(resetn_in) |-> processor_status_mirror == `SBD_MIRROR_RST;
	endproperty
	a_mirror_reset: assert property (p_mirror_reset)
		else $error("mirror not zero after reset");

	property p_id_read;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && !data_req_in.we && data_req_in.addr == `SBD_ID_ADDR
		|=> data_resp_valid_out && data_rdata_out[7:0] == CORE_ID;
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("identification read wrong");

	property p_stack_word;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && data_req_in.we && data_req_in.stack &&
		data_req_in.size == `SBD_SZ_WORD && !dec_d.local_only
		|=> data_bus_out.wdata[31:24] == $past(core_status_word_in);
	endproperty
	a_stack_word: assert property (p_stack_word)
		else $error("stacked word lacks status byte");

	property p_flash_write;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && data_req_in.we && dec_d.area == sbd_pkg::SBD_AREA_FLASH
		&& data_req_in.size != `SBD_SZ_HALF |=> !data_bus_out.req;
	endproperty
	a_flash_write: assert property (p_flash_write)
		else $error("non-halfword flash write reached the bus");

	property p_serial_flash;
		@(posedge mclk_in) disable iff (!resetn_in)
		fetch_bus_out.req && f_area == sbd_pkg::SBD_AREA_FLASH &&
		(d_area == sbd_pkg::SBD_AREA_FLASH ||
		d_area == sbd_pkg::SBD_AREA_DISP) |-> !data_bus_out.req;
	endproperty
	a_serial_flash: assert property (p_serial_flash)
		else $error("flash fetch overlapped data access");

	property p_serial_ram;
		@(posedge mclk_in) disable iff (!resetn_in)
		fetch_bus_out.req && data_bus_out.req |->
			!conflict(f_area, d_area);
	endproperty
	a_serial_ram: assert property (p_serial_ram)
		else $error("conflicting fetch and data overlapped");

	property p_ram_one;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && dec_d.area == sbd_pkg::SBD_AREA_RAM
		|=> data_bus_out.req ##1 data_resp_valid_out && !data_bus_out.req;
	endproperty
	a_ram_one: assert property (p_ram_one)
		else $error("RAM access not one cycle");

	property p_p1_one;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && dec_d.area == sbd_pkg::SBD_AREA_P1 &&
		data_req_in.size == `SBD_SZ_BYTE
		|=> data_bus_out.req ##1 data_resp_valid_out;
	endproperty
	a_p1_one: assert property (p_p1_one)
		else $error("area one access not one cycle");

	property p_p2_one;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && dec_d.area == sbd_pkg::SBD_AREA_P2 &&
		!dec_d.local_only && data_req_in.size == `SBD_SZ_BYTE
		|=> data_bus_out.req ##1 data_resp_valid_out;
	endproperty
	a_p2_one: assert property (p_p2_one)
		else $error("area two access not one cycle");

	property p_core_decode;
		@(posedge mclk_in) disable iff (!resetn_in)
		data_valid_in && data_req_in.addr >= `SBD_CORE_BASE
		|-> dec_d.area == sbd_pkg::SBD_AREA_CORE;
	endproperty
	a_core_decode: assert property (p_core_decode)
		else $error("core I/O address misdecoded");

	property p_dbg_decode;
		@(posedge mclk_in) disable iff (!resetn_in)
		data_valid_in && data_req_in.addr >= `SBD_DBG_BASE &&
		data_req_in.addr <= `SBD_RAM_END
		|-> dec_d.area == sbd_pkg::SBD_AREA_DBG;
	endproperty
	a_dbg_decode: assert property (p_dbg_decode)
		else $error("debug RAM address misdecoded");

	property p_flash_decode;
		@(posedge mclk_in) disable iff (!resetn_in)
		data_valid_in && data_req_in.addr >= `SBD_FL_BASE &&
		data_req_in.addr <= `SBD_FL_END
		|-> dec_d.area == sbd_pkg::SBD_AREA_FLASH && dec_d.width == `SBD_W16;
	endproperty
	a_flash_decode: assert property (p_flash_decode)
		else $error("flash address misdecoded");

	property p_unmapped;
		@(posedge mclk_in) disable iff (!resetn_in)
		d_acc && dec_d.area == sbd_pkg::SBD_AREA_NONE
		|=> data_resp_valid_out && !data_bus_out.req &&
			data_rdata_out == `SBD_ZERO_WORD;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not answered with zero");
endmodule

// ### inc/sbd_cfg.svh
// Address map, field and timing constants of the system bus front end
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH
`define SBD_RAM_END 24'h001fff
`define SBD_DBG_BASE 24'h001fc0
`define SBD_P1_BASE 24'h004000
`define SBD_P1_NARROW_END 24'h0041ff
`define SBD_P1_END 24'h004fff
`define SBD_P2_BASE 24'h005000
`define SBD_P2_WIDE_BASE 24'h005300
`define SBD_DISP_BASE 24'h0053c0
`define SBD_DISP_END 24'h0053ff
`define SBD_P2_END 24'h005fff
`define SBD_FL_BASE 24'h008000
`define SBD_FL_END 24'h027fff
`define SBD_CORE_BASE 24'hfffc00
`define SBD_MIRROR_ADDR 24'h00532c
`define SBD_MIRROR_LAST 24'h00532d
`define SBD_ID_ADDR 24'hffff84
// Arbitrary value, chosen to name no real core
`define SBD_ID_CODE 8'h5a
`define SBD_MIRROR_RST 8'h00
`define SBD_ZERO_BYTE 8'h00
`define SBD_ZERO_WORD 32'h00000000
`define SBD_MASK8 32'h000000ff
`define SBD_MASK16 32'h0000ffff
`define SBD_MASK32 32'hffffffff
`define SBD_LOW24 32'h00ffffff
`define SBD_W8 2'h0
`define SBD_W16 2'h1
`define SBD_W32 2'h2
`define SBD_SZ_BYTE 2'h0
`define SBD_SZ_HALF 2'h1
`define SBD_SZ_WORD 2'h2
`define SBD_CYC_NONE 3'h0
`define SBD_CYC_ONE 3'h1
`define SBD_FL_CYC_MAX 3'h5
`define SBD_ONE_BEAT 3'h1
`define SBD_ONE_ADDR 24'h000001
`define SBD_BYTE_BITS 5'h08
`endif

// ### inc/sbd_pkg.sv
// Shared types of the system bus front end
package sbd_pkg;
	typedef enum logic [2:0] {
		SBD_AREA_NONE, SBD_AREA_RAM, SBD_AREA_DBG, SBD_AREA_P1,
		SBD_AREA_P2, SBD_AREA_DISP, SBD_AREA_FLASH, SBD_AREA_CORE
	} sbd_area_t;
	typedef struct packed {
		logic [23:0] addr;
		logic [1:0] size;
		logic we;
		logic stack;
		logic [31:0] wdata;
	} sbd_cpu_req_t;
	typedef struct packed {
		sbd_area_t area;
		logic [1:0] width;
		logic [2:0] cycles;
		logic local_only;
	} sbd_decode_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] width;
		logic [23:0] addr;
		logic [31:0] wdata;
	} sbd_bus_req_t;
	typedef struct packed {
		logic [2:0] irq_level_copy;
		logic irq_enable_copy;
		logic carry_flag_copy;
		logic overflow_flag_copy;
		logic zero_flag_copy;
		logic negative_flag_copy;
	} sbd_status_t;
endpackage

// ### verification/sbd_mem_model.sv
// Memory and peripheral model behind the front end's bus ports
`timescale 1ns/1ns
module sbd_mem_model (
	input wire logic mclk_in,
	input wire sbd_pkg::sbd_bus_req_t bus_in,
	output logic [31:0] rdata_out
);
	logic [31:0] last = 32'h00000000;
	logic [7:0] a;
	assign a = bus_in.addr[7:0];
	// Idle cycles show inverted old data so stale sampling is caught
	assign rdata_out = bus_in.req ?
		{a + 8'h03, a + 8'h02, a + 8'h01, a} : ~last;
	always @(posedge mclk_in) begin
		if (bus_in.req)
			last <= rdata_out;
	end
endmodule

// ### verification/tb.sv
// Self-checking testbench of the system bus front end
`timescale 1ns/1ns
module tb;
	// Value is arbitrary
	localparam logic [7:0] ID = 8'h3c;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] st = 8'h00;
	logic [2:0] fc = 3'h1;
	logic [1:0] v = 2'h0;
	sbd_pkg::sbd_cpu_req_t rq [2];
	wire [1:0] rdy, rv;
	wire [31:0] rd [2];
	wire [31:0] bi [2];
	wire sbd_pkg::sbd_bus_req_t bo [2];
	int n_fail = 0;
	int n_checks = 0;
	int nb [2];
	int ov = 0;
	logic [31:0] wd;
	logic [1:0] ww;
	always #2 mclk_in = ~mclk_in;
	sbd_bus_front #(.CORE_ID(ID)) dut (.mclk_in(mclk_in),
		.resetn_in(resetn_in), .ce_in(1'b1), .core_status_word_in(st),
		.flash_cycles_in(fc), .fetch_valid_in(v[1]), .fetch_req_in(rq[1]),
		.fetch_ready_out(rdy[1]), .fetch_resp_valid_out(rv[1]),
		.fetch_rdata_out(rd[1]), .data_valid_in(v[0]), .data_req_in(rq[0]),
		.data_ready_out(rdy[0]), .data_resp_valid_out(rv[0]),
		.data_rdata_out(rd[0]), .fetch_bus_out(bo[1]),
		.fetch_bus_rdata_in(bi[1]), .data_bus_out(bo[0]),
		.data_bus_rdata_in(bi[0]));
	sbd_mem_model m0 (.mclk_in(mclk_in), .bus_in(bo[0]), .rdata_out(bi[0]));
	sbd_mem_model m1 (.mclk_in(mclk_in), .bus_in(bo[1]), .rdata_out(bi[1]));
	// Bus lines sampled mid-cycle, away from the launching edge
	always @(negedge mclk_in) begin
		for (int k = 0; k < 2; k++) begin
			if (bo[k].req === 1'b1) begin
				nb[k]++;
				ww = bo[k].width;
				if (bo[k].we === 1'b1)
					wd = bo[k].wdata;
			end
		end
		if (bo[0].req === 1'b1 && bo[1].req === 1'b1)
			ov++;
	end
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic acc(input int p, input logic [23:0] ad,
		input logic [1:0] sz, input logic we, input logic sk,
		input logic [31:0] w, input int nc, input logic [31:0] ed);
		int n;
		n = 0;
		@(negedge mclk_in);
		rq[p] = '{ad, sz, we, sk, w};
		v[p] = 1'b1;
		nb[p] = 0;
		#1;
		while (rdy[p] !== 1'b1) begin
			@(negedge mclk_in);
			#1;
		end
		@(posedge mclk_in);
		do begin
			@(negedge mclk_in);
			v[p] = 1'b0;
			n++;
		end while (rv[p] !== 1'b1 && n < 40);
		chk(n == nc + 1, "latency");
		chk(nb[p] == nc, "bus cycles");
		if (!we)
			chk(rd[p] === ed, "read data");
	endtask
	task automatic t_mirror;
		acc(0, 'h532c, 1, 0, 0, 0, 0, 'h0);
		st = 8'hb5;
		acc(0, 'h532c, 1, 0, 0, 0, 0, 'h00b5);
		acc(0, 'h532c, 1, 1, 0, 'hffff, 0, 0);
		acc(0, 'h532c, 1, 0, 0, 0, 0, 'h00b5);
		acc(0, 'h532c, 2, 0, 0, 0, 0, 'h000000b5);
		st = 8'h4a;
		acc(0, 'h532c, 1, 0, 0, 0, 0, 'h004a);
		$display("mirror test done");
	endtask
	task automatic t_id;
		acc(0, 'hffff84, 0, 0, 0, 0, 0, ID);
		acc(0, 'hffff84, 0, 1, 0, 'h00, 0, 0);
		acc(0, 'hffff84, 0, 0, 0, 0, 0, ID);
		$display("id test done");
	endtask
	task automatic t_split;
		acc(0, 'h0000, 2, 0, 0, 0, 1, 'h00020100);
		acc(0, 'h1fc0, 2, 0, 0, 0, 1, 'h00c2c1c0);
		acc(0, 'h5000, 1, 0, 0, 0, 2, 'h0100);
		acc(0, 'h5000, 2, 0, 0, 0, 4, 'h00020100);
		acc(0, 'h4200, 2, 0, 0, 0, 2, 'h00020100);
		chk(ww === 2'h1, "device width");
		acc(0, 'h4001, 0, 0, 0, 0, 1, 'h01);
		acc(0, 'h2000, 2, 0, 0, 0, 0, 'h0);
		$display("split test done");
	endtask
	task automatic t_flash;
		fc = 3'h3;
		acc(0, 'h8000, 0, 0, 0, 0, 3, 'h00);
		fc = 3'h5;
		acc(0, 'h8000, 1, 0, 0, 0, 5, 'h0100);
		fc = 3'h1;
		acc(0, 'h8000, 2, 0, 0, 0, 2, 'h00020100);
		$display("flash test done");
	endtask
	task automatic t_write;
		acc(0, 'h0000, 2, 1, 0, 'hffffffff, 1, 0);
		chk(wd === 32'h00ffffff, "word write top byte");
		acc(0, 'h0000, 2, 1, 1, 'hffffffff, 1, 0);
		chk(wd === {st, 24'hffffff}, "stack write");
		acc(0, 'h8000, 0, 1, 0, 'h12, 0, 0);
		acc(0, 'h8000, 1, 1, 0, 'h1234, 1, 0);
		chk(wd[15:0] === 16'h1234, "flash halfword write");
		acc(0, 'h2000, 2, 1, 0, 'h55, 0, 0);
		$display("write test done");
	endtask
	task automatic t_conflict;
		fc = 3'h2;
		ov = 0;
		fork
			acc(1, 'h8000, 1, 0, 0, 0, 2, 'h0100);
			acc(0, 'h8002, 1, 0, 0, 0, 2, 'h0302);
		join
		fork
			acc(1, 'h8000, 1, 0, 0, 0, 2, 'h0100);
			acc(0, 'h53c0, 1, 0, 0, 0, 1, 'hc1c0);
		join
		fork
			acc(1, 'h0000, 2, 0, 0, 0, 1, 'h00020100);
			acc(0, 'h0100, 2, 0, 0, 0, 1, 'h00020100);
		join
		chk(ov == 0, "fetch and data overlapped");
		$display("conflict test done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		rq[0] = '0;
		rq[1] = '0;
		repeat (12) @(posedge mclk_in);
		@(negedge mclk_in);
		resetn_in = 1'b1;
		t_mirror;
		t_id;
		t_split;
		t_flash;
		t_write;
		t_conflict;
		test_done;
	end
	// Whole run needs little more than a hundred cycles
	initial begin
		#20000;
		n_fail++;
		test_done;
	end
endmodule
